// file: rtl/cond_branch_ge_unit.sv
// Purpose: Executes signed/unsigned greater-or-equal and signed less-than branches
// Assumes: Register file answers reads combinationally in the same cycle
// Notes: One instruction per valid cycle; results registered one cycle later
// Behaviour
// - Signed ge: taken when first not signed-less than second; target PC+4+offset
// - Unsigned ge: same as signed form but operands compared unsigned
// - Offset counts bytes from the instruction following the branch
// - Sixteen-bit offset is sign-extended to address width before adding
// - Taken branch with misaligned target raises misaligned-destination exception
// - Two register-index fields pick the operands that the comparison reads
// - Signed less-than taken when first signed-less than second; else PC+4
module cond_branch_ge_unit
  import cond_branch_pkg::*;
(
  input wire logic clock_i,                        // Core clock, 20 MHz
  input wire logic resetn_i,                       // Synchronous reset, active low
  input wire logic instr_valid_i,                  // Instruction word valid
  input wire logic [INSTR_W-1:0] instr_i,          // Instruction word
  input wire logic [ADDR_W-1:0] pc_i,              // Address of the branch
  input wire logic [ADDR_W-1:0] first_operand_reg_i,  // Value read at first index
  input wire logic [ADDR_W-1:0] second_operand_reg_i, // Value read at second index
  output logic [REG_IDX_W-1:0] first_idx_o,        // First read index, combinational
  output logic [REG_IDX_W-1:0] second_idx_o,       // Second read index, combinational
  output logic next_pc_valid_o,                    // Next PC result valid pulse
  output logic [ADDR_W-1:0] next_pc_o,             // Next program counter
  output logic taken_o,                            // Branch was taken
  output logic misaligned_exc_o                    // Misaligned destination pulse
);
  branch_decode_if dec_bus ();

  logic res_valid;
  logic [ADDR_W-1:0] res_pc;
  logic res_taken;
  logic res_exc;
  logic next_res_valid;
  logic [ADDR_W-1:0] next_res_pc;
  logic next_res_taken;
  logic next_res_exc;
  logic [ADDR_W-1:0] seq_pc;
  logic [ADDR_W-1:0] target_pc;
  logic cond;

  // Address adder, used twice: PC plus step, then sequential address plus extended offset
  function automatic logic [ADDR_W-1:0] add_addr(input logic [ADDR_W-1:0] a,
                                                  input logic [ADDR_W-1:0] b);
    add_addr = a + b;
  endfunction

  branch_decoder u_decoder (
    .instr_i (instr_i),
    .dec     (dec_bus.decoder)
  );

  // Register index fields feed the register file read ports
  // Left unregistered: the file must answer within the same cycle
  always_comb begin
    first_idx_o = dec_bus.first_idx;
    second_idx_o = dec_bus.second_idx;
  end

  // Condition and target computation
  always_comb begin
    seq_pc = add_addr(pc_i, SEQ_STEP);
    target_pc = add_addr(seq_pc, dec_bus.offset_ext);
    case (dec_bus.kind)
      BR_GE_S: cond = !($signed(first_operand_reg_i) < $signed(second_operand_reg_i));
      BR_GE_U: cond = !(first_operand_reg_i < second_operand_reg_i);
      BR_LT_S: cond = $signed(first_operand_reg_i) < $signed(second_operand_reg_i);
      default: cond = 1'b0;
    endcase
    next_res_valid = instr_valid_i && (dec_bus.kind != BR_NONE);
    next_res_taken = next_res_valid && cond;
    // Misaligned target faults; the PC still reports the target for the handler
    next_res_exc = next_res_taken && ((target_pc[1:0] & ALIGN_MASK) != 2'h0);
    next_res_pc = next_res_taken ? target_pc : seq_pc;
    // Idle and foreign words keep the last reported PC
    if (!next_res_valid) begin
      next_res_pc = res_pc;
    end
  end

  // Result registers; outputs come straight from these
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      res_valid <= 1'b0;
      res_pc <= PC_RESET;
      res_taken <= 1'b0;
      res_exc <= 1'b0;
    end else begin
      res_valid <= next_res_valid;
      res_pc <= next_res_pc;
      res_taken <= next_res_taken;
      res_exc <= next_res_exc;
    end
  end

  assign next_pc_valid_o = res_valid;
  assign next_pc_o = res_pc;
  assign taken_o = res_taken;
  assign misaligned_exc_o = res_exc;

  // Checks next to the logic; each label line names its rule

  // Signed ge with first not below second goes to the target
  a_ge_signed_taken: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && dec_bus.kind == BR_GE_S &&
    $signed(first_operand_reg_i) >= $signed(second_operand_reg_i)
    |=> taken_o && next_pc_o == $past(pc_i) + 32'h0000_0004 + $past(dec_bus.offset_ext))
    else $error("signed ge branch not taken to target");

  // Signed ge with first below second steps to the next word
  a_ge_signed_fall: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && dec_bus.kind == BR_GE_S &&
    $signed(first_operand_reg_i) < $signed(second_operand_reg_i)
    |=> !taken_o && next_pc_o == $past(pc_i) + 32'h0000_0004)
    else $error("signed ge branch fall-through wrong");

  // Unsigned verdict judged on the sampled operands
  a_ge_unsigned_cond: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && dec_bus.kind == BR_GE_U
    |=> taken_o == ($past(first_operand_reg_i) >= $past(second_operand_reg_i)))
    else $error("unsigned ge condition wrong");

  // Displacement counts from the following instruction
  a_offset_from_next: assert property (@(posedge clock_i) disable iff (!resetn_i)
    taken_o |-> next_pc_o - $past(pc_i) - 32'h0000_0004 == $past(dec_bus.offset_ext))
    else $error("offset not relative to following instruction");

  // Upper half copies the offset sign bit
  a_offset_sign_ext: assert property (@(posedge clock_i)
    dec_bus.offset_ext[31:16] == {16{instr_i[21]}} && dec_bus.offset_ext[15:0] == instr_i[21:6])
    else $error("offset sign extension wrong");

  // Fault stands exactly when a taken target is misaligned
  a_misaligned_exc: assert property (@(posedge clock_i) disable iff (!resetn_i)
    misaligned_exc_o == (taken_o && next_pc_o[1:0] != 2'h0))
    else $error("misaligned exception mismatch");

  // Read indices follow the instruction fields at once
  a_index_fields: assert property (@(posedge clock_i)
    first_idx_o == instr_i[31:27] && second_idx_o == instr_i[26:22])
    else $error("register index fields wrong");

  // Signed lt verdict judged on the sampled operands
  a_lt_signed_cond: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && dec_bus.kind == BR_LT_S
    |=> taken_o == ($signed($past(first_operand_reg_i)) < $signed($past(second_operand_reg_i))))
    else $error("signed lt condition wrong");

  // Both ge opcodes are answered
  a_opcode_decode: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && (instr_i[5:0] == 6'h0e || instr_i[5:0] == 6'h2e) |=> next_pc_valid_o)
    else $error("ge opcode not decoded");

  // Unsigned ge taken goes to the offset target
  a_ge_unsigned_taken: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && dec_bus.kind == BR_GE_U && first_operand_reg_i >= second_operand_reg_i
    |=> taken_o && next_pc_o == $past(pc_i) + 32'h0000_0004 + $past(dec_bus.offset_ext))
    else $error("unsigned ge branch not taken to target");

  // Unsigned ge not taken steps to the next word
  a_ge_unsigned_fall: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && dec_bus.kind == BR_GE_U && first_operand_reg_i < second_operand_reg_i
    |=> !taken_o && next_pc_o == $past(pc_i) + 32'h0000_0004)
    else $error("unsigned ge branch fall-through wrong");

  // Signed lt taken goes to the target; swapped greater-than rides on this
  a_lt_signed_taken: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && dec_bus.kind == BR_LT_S &&
    $signed(first_operand_reg_i) < $signed(second_operand_reg_i)
    |=> taken_o && next_pc_o == $past(pc_i) + 32'h0000_0004 + $past(dec_bus.offset_ext))
    else $error("signed lt branch not taken to target");

  // Signed lt not taken steps to the next word
  a_lt_signed_fall: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && dec_bus.kind == BR_LT_S &&
    !($signed(first_operand_reg_i) < $signed(second_operand_reg_i))
    |=> !taken_o && next_pc_o == $past(pc_i) + 32'h0000_0004)
    else $error("signed lt branch fall-through wrong");

  // Any answered branch that is not taken steps four bytes on
  a_seq_fall: assert property (@(posedge clock_i) disable iff (!resetn_i)
    next_pc_valid_o && !taken_o |-> next_pc_o == $past(pc_i) + 32'h0000_0004)
    else $error("fall-through pc not next instruction");

  // Target rebuilt from raw instruction bits, independent of the decoder
  a_taken_target: assert property (@(posedge clock_i) disable iff (!resetn_i)
    taken_o |-> next_pc_o == $past(pc_i) + 32'h0000_0004 +
      {{16{$past(instr_i[21])}}, $past(instr_i[21:6])})
    else $error("taken target not built from extended offset");

  // Without an answer the reported PC must not move; skipped just after reset
  a_pc_hold: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !next_pc_valid_o && $past(resetn_i) |-> $stable(next_pc_o))
    else $error("next pc moved without a branch");

  // Every valid branch word gets an answer one cycle later
  a_result_pulse: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && dec_bus.kind != BR_NONE |=> next_pc_valid_o)
    else $error("valid branch gave no answer");

  // Idle cycles and foreign opcodes raise nothing
  a_refuse_other: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !(instr_valid_i && dec_bus.kind != BR_NONE)
    |=> !next_pc_valid_o && !taken_o && !misaligned_exc_o)
    else $error("answer without a valid branch");

  // Taken only ever accompanies an answer
  a_taken_valid: assert property (@(posedge clock_i) disable iff (!resetn_i)
    taken_o |-> next_pc_valid_o)
    else $error("taken without valid");

  // The fault belongs to taken branches only
  a_exc_taken: assert property (@(posedge clock_i) disable iff (!resetn_i)
    misaligned_exc_o |-> taken_o && next_pc_valid_o)
    else $error("misaligned fault on untaken branch");

  // Fault predicted from the low PC and offset bits alone
  a_exc_low_bits: assert property (@(posedge clock_i) disable iff (!resetn_i)
    taken_o |-> misaligned_exc_o == (2'($past(pc_i[1:0]) + $past(instr_i[7:6])) != 2'h0))
    else $error("misaligned fault does not match target bits");

  // The less-than opcode is answered like the two ge forms
  a_lt_opcode: assert property (@(posedge clock_i) disable iff (!resetn_i)
    instr_valid_i && instr_i[5:0] == 6'h16 |=> next_pc_valid_o)
    else $error("lt opcode not decoded");
endmodule

// file: rtl/cond_branch_pkg.sv
// Purpose: Shared constants and types for the conditional branch unit
// Assumes: 32-bit instruction word and 32-bit addresses
// Notes: Field positions and opcodes used by decoder and executor
package cond_branch_pkg;
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned INSTR_W = 32;
  localparam int unsigned REG_IDX_W = 5;
  localparam int unsigned OFFSET_W = 16;
  localparam int unsigned OPCODE_W = 6;
  // Field positions inside the instruction word
  localparam int unsigned FIRST_REG_LSB = 27;
  localparam int unsigned SECOND_REG_LSB = 22;
  localparam int unsigned OFFSET_LSB = 6;
  localparam int unsigned OPCODE_LSB = 0;
  // Opcodes
  localparam logic [5:0] OPC_BR_GE_S = 6'h0e;
  localparam logic [5:0] OPC_BR_GE_U = 6'h2e;
  localparam logic [5:0] OPC_BR_LT_S = 6'h16;
  // Sequential step in bytes
  localparam logic [31:0] SEQ_STEP = 32'h0000_0004;
  // Reset value and alignment mask
  localparam logic [31:0] PC_RESET = 32'h0000_0000;
  localparam logic [1:0] ALIGN_MASK = 2'h3;

  typedef enum {
    BR_NONE,
    BR_GE_S,
    BR_GE_U,
    BR_LT_S
  } branch_kind_t;
endpackage

// file: rtl/branch_decode_if.sv
// Purpose: Carries decoded branch fields from decoder to executor
// Assumes: Single core clock
// Notes: Purely combinational bundle
interface branch_decode_if;
  import cond_branch_pkg::*;
  cond_branch_pkg::branch_kind_t kind;
  logic [REG_IDX_W-1:0] first_idx;
  logic [REG_IDX_W-1:0] second_idx;
  logic [ADDR_W-1:0] offset_ext;
  modport decoder (output kind, output first_idx, output second_idx, output offset_ext);
  modport executor (input kind, input first_idx, input second_idx, input offset_ext);
endinterface

// file: rtl/branch_decoder.sv
// Purpose: Splits an instruction word into branch fields
// Assumes: Instruction word is stable while valid
// Notes: Unknown opcodes decode as no branch
module branch_decoder
  import cond_branch_pkg::*;
(
  input wire logic [INSTR_W-1:0] instr_i, // Instruction word
  branch_decode_if.decoder dec           // Decoded fields
);
  logic [OFFSET_W-1:0] branch_offset_field;
  logic [OPCODE_W-1:0] opcode;

  // Field extraction and sign extension
  always_comb begin
    opcode = instr_i[OPCODE_LSB +: OPCODE_W];
    branch_offset_field = instr_i[OFFSET_LSB +: OFFSET_W];
    dec.first_idx = instr_i[FIRST_REG_LSB +: REG_IDX_W];
    dec.second_idx = instr_i[SECOND_REG_LSB +: REG_IDX_W];
    // Sign-extend to the full address width
    dec.offset_ext = {{(ADDR_W-OFFSET_W){branch_offset_field[OFFSET_W-1]}},
                      branch_offset_field};
    case (opcode)
      OPC_BR_GE_S: dec.kind = BR_GE_S;
      OPC_BR_GE_U: dec.kind = BR_GE_U;
      OPC_BR_LT_S: dec.kind = BR_LT_S;
      default: dec.kind = BR_NONE;
    endcase
  end
endmodule

// file: tb/regfile_model.sv
// Purpose: Register file model that answers two reads in the same cycle
// Assumes: Only the bench writes it, one register per clock
// Notes: Reads are combinational because the unit compares in one cycle
module regfile_model
  import cond_branch_pkg::*;
(
  input wire logic clock_i,                      // Core clock
  input wire logic wr_en_i,                      // Write strobe
  input wire logic [REG_IDX_W-1:0] wr_idx_i,     // Write index
  input wire logic [ADDR_W-1:0] wr_data_i,       // Write data
  input wire logic [REG_IDX_W-1:0] first_idx_i,  // First read index
  input wire logic [REG_IDX_W-1:0] second_idx_i, // Second read index
  output logic [ADDR_W-1:0] first_data_o,        // First read data
  output logic [ADDR_W-1:0] second_data_o        // Second read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [ADDR_W-1:0] regs [32];
  // Bench loads values before the first branch
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      regs[wr_idx_i] <= wr_data_i;
    end
  end
  // Read ports follow the indices at once
  assign first_data_o = regs[first_idx_i];
  assign second_data_o = regs[second_idx_i];
endmodule

// file: tb/cond_branch_ge_unit_tb.sv
// Purpose: Self-checking bench for the greater-or-equal branch unit
// Assumes: Registers 1 to 4 hold -1, 1, most negative, most positive
// Notes: One idle cycle between branches keeps each request single
module cond_branch_ge_unit_tb
  import cond_branch_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, resetn_i = 0, instr_valid_i = 0, wr_en = 0;
  logic next_pc_valid_o, taken_o, misaligned_exc_o;
  logic [31:0] instr_i = '0, pc_i = '0, wr_data = '0, a_data, b_data, next_pc_o, last_pc = '0;
  logic [4:0] wr_idx = '0, first_idx_o, second_idx_o;
  int fails = 0, compares = 0, cycles = 0;
  always #25 clock_i = ~clock_i;
  cond_branch_ge_unit dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .pc_i(pc_i),
    .first_operand_reg_i(a_data), .second_operand_reg_i(b_data),
    .first_idx_o(first_idx_o), .second_idx_o(second_idx_o),
    .next_pc_valid_o(next_pc_valid_o), .next_pc_o(next_pc_o), .taken_o(taken_o),
    .misaligned_exc_o(misaligned_exc_o));
  regfile_model rf (.clock_i(clock_i), .wr_en_i(wr_en), .wr_idx_i(wr_idx),
    .wr_data_i(wr_data), .first_idx_i(first_idx_o), .second_idx_i(second_idx_o),
    .first_data_o(a_data), .second_data_o(b_data));
  task results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One branch: request at c0, answer read in c1, pulse drop seen next call
  task issue(input logic [5:0] opc, input logic [4:0] ia, input logic [4:0] ib,
      input logic [15:0] off, input logic [31:0] pc, input logic vld, input logic tk);
    logic [31:0] exp;
    exp = !vld ? last_pc : (tk ? pc + SEQ_STEP + {{16{off[15]}}, off} : pc + SEQ_STEP);
    @(posedge clock_i);
    instr_i <= {ia, ib, off, opc};
    pc_i <= pc;
    instr_valid_i <= 1'b1;
    #1;
    check("valid_drop", 32'(next_pc_valid_o), '0);
    check("first_idx", 32'(first_idx_o), 32'(ia));
    check("second_idx", 32'(second_idx_o), 32'(ib));
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    #1;
    check("valid", 32'(next_pc_valid_o), 32'(vld));
    check("next_pc", next_pc_o, exp);
    check("taken", 32'(taken_o), 32'(tk));
    check("exc", 32'(misaligned_exc_o), 32'(tk && exp[1:0] != 2'h0));
    if (vld) last_pc = exp;
  endtask
  // Signed compare, equal operands and a backward offset
  task t_signed();
    issue(OPC_BR_GE_S, 5'd2, 5'd1, 16'h0010, 32'h0000_1000, 1'b1, 1'b1);
    issue(OPC_BR_GE_S, 5'd1, 5'd2, 16'h0010, 32'h0000_1000, 1'b1, 1'b0);
    issue(OPC_BR_GE_S, 5'd4, 5'd3, 16'hfff0, 32'h0000_2000, 1'b1, 1'b1);
    issue(OPC_BR_GE_S, 5'd2, 5'd2, 16'h0004, 32'h0000_3000, 1'b1, 1'b1);
  endtask
  // Unsigned compare flips the verdict on sign-bit operands
  task t_unsigned();
    issue(OPC_BR_GE_U, 5'd1, 5'd2, 16'h0100, 32'h0000_4000, 1'b1, 1'b1);
    issue(OPC_BR_GE_U, 5'd4, 5'd3, 16'h0100, 32'h0000_4000, 1'b1, 1'b0);
    issue(OPC_BR_GE_U, 5'd3, 5'd3, 16'h8000, 32'h0001_0000, 1'b1, 1'b1);
  endtask
  // Greater-than sent as less-than with operands swapped
  task t_alias();
    issue(OPC_BR_LT_S, 5'd1, 5'd2, 16'h0020, 32'h0000_5000, 1'b1, 1'b1);
    issue(OPC_BR_LT_S, 5'd2, 5'd1, 16'h0020, 32'h0000_5000, 1'b1, 1'b0);
  endtask
  // Bad low offset bits fault only when the branch is taken
  task t_misalign();
    issue(OPC_BR_GE_S, 5'd2, 5'd1, 16'h0006, 32'h0000_6000, 1'b1, 1'b1);
    issue(OPC_BR_GE_U, 5'd2, 5'd1, 16'h0001, 32'h0000_6000, 1'b1, 1'b0);
    issue(OPC_BR_GE_U, 5'd1, 5'd1, 16'h0004, 32'h0000_7000, 1'b1, 1'b1);
  endtask
  // Foreign opcodes give no answer and leave the PC alone
  task t_refuse();
    issue(6'h26, 5'd1, 5'd2, 16'h0010, 32'h0000_8000, 1'b0, 1'b0);
    issue(6'h3f, 5'd2, 5'd1, 16'h0010, 32'h0000_8000, 1'b0, 1'b0);
  endtask
  // Back-to-back branches; each result stands for exactly one cycle
  task t_back_to_back();
    @(posedge clock_i);
    instr_i <= {5'h02, 5'h01, 16'h0008, OPC_BR_GE_S};
    pc_i <= 32'h0000_9000;
    instr_valid_i <= 1'b1;
    @(posedge clock_i);
    instr_i <= {5'h01, 5'h02, 16'h0008, OPC_BR_GE_U};
    pc_i <= 32'h0000_a000;
    #1;
    check("b2b_pc0", next_pc_o, 32'h0000_900c);
    check("b2b_valid0", 32'(next_pc_valid_o), 32'h0000_0001);
    @(posedge clock_i);
    instr_valid_i <= 1'b0;
    #1;
    check("b2b_pc1", next_pc_o, 32'h0000_a00c);
    check("b2b_taken1", 32'(taken_o), 32'h0000_0001);
    @(posedge clock_i);
    #1;
    check("b2b_drop", 32'(next_pc_valid_o), 32'h0000_0000);
    last_pc = 32'h0000_a00c;
  endtask
  // A branch word without valid gives no answer and keeps the PC
  task t_no_valid();
    @(posedge clock_i);
    instr_i <= {5'h02, 5'h01, 16'h0010, OPC_BR_GE_S};
    pc_i <= 32'h0000_b000;
    @(posedge clock_i);
    #1;
    check("novalid_valid", 32'(next_pc_valid_o), 32'h0000_0000);
    check("novalid_pc", next_pc_o, last_pc);
    check("novalid_taken", 32'(taken_o), 32'h0000_0000);
  endtask
  // Reset in mid-run clears the results; the next branch works at once
  task t_reset();
    @(posedge clock_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    #1;
    check("rst_pc", next_pc_o, PC_RESET);
    check("rst_valid", 32'(next_pc_valid_o), 32'h0000_0000);
    last_pc = PC_RESET;
    issue(OPC_BR_GE_S, 5'h04, 5'h03, 16'h0000, 32'h0000_c000, 1'b1, 1'b1);
  endtask
  // Hang guard, far above the few dozen cycles needed
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 1000) begin
      fails++;
      results();
    end
  end
  initial begin
    for (int i = 1; i <= 4; i++) begin
      @(posedge clock_i);
      wr_en <= 1'b1;
      wr_idx <= 5'(i);
      wr_data <= (i == 1) ? 32'hffff_ffff : (i == 2) ? 32'h0000_0001 :
                 (i == 3) ? 32'h8000_0000 : 32'h7fff_ffff;
    end
    @(posedge clock_i);
    wr_en <= 1'b0;
    repeat (5) @(posedge clock_i);
    resetn_i <= 1'b1;
    #1;
    check("reset_pc", next_pc_o, '0);
    check("reset_valid", 32'(next_pc_valid_o), 32'h0000_0000);
    t_signed();
    t_unsigned();
    t_alias();
    t_misalign();
    t_refuse();
    t_back_to_back();
    t_no_valid();
    t_reset();
    results();
  end
endmodule
